// file: core/servo_guard_cfg.svh
// Offsets, field positions, reset values and codes for the parameter guard
`ifndef SERVO_GUARD_CFG_SVH
`define SERVO_GUARD_CFG_SVH

// Register byte offsets
`define OFS_REGEN 8'h00
`define OFS_ABS 8'h04
`define OFS_STOP 8'h08
`define OFS_PROT 8'h0C
`define OFS_ACTIVE 8'h10
`define OFS_ACCESS 8'h14
`define OFS_MODE 8'h18
`define OFS_STATUS 8'h1C
`define OFS_MASK 8'h20
`define OFS_GROUP 8'h24
`define OFS_CTRL 8'h28

// Reset values
`define RST_REGEN 16'h0000
`define RST_ABS 16'h0000
`define RST_STOP 16'h0000
`define RST_PROT 16'h000B

// Protection level codes
`define PROT_BASIC 16'h0000
`define PROT_B 16'h000B
`define PROT_C 16'h000C
`define PROT_F 16'h000F
`define PROT_RO_B 16'h100B
`define PROT_RO_C 16'h100C

// Forced-stop selection field (low byte of the stop selection)
`define STOP_SEL_LSB 0
`define STOP_SEL_W 8
`define STOP_SEL_00 8'h00
`define STOP_SEL_10 8'h10
`define STOP_SEL_30 8'h30
`define STOP_SEL_01 8'h01
`define STOP_SEL_11 8'h11
`define STOP_SEL_31 8'h31

// Regenerative option field (low two digits) and permitted code mask
`define REGEN_SEL_W 8
`define REGEN_NONE 8'h00
`define REGEN_ALLOWED_DEFAULT 256'h0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0001

// Absolute selection enable bit
`define ABS_EN_BIT 0

// Mode register fields
`define MODE_CTRL_LSB 0
`define MODE_LIN_INC_BIT 2
`define MODE_LOOP_SW_BIT 3

// Status bit positions
`define ST_PARAM_ERR 0
`define ST_WR_BLOCKED 1
`define ST_RD_BLOCKED 2
`define ST_STOP 3
`define ST_BRAKE 4

// Control register bits
`define CTRL_CTRL_RESET 0
`define CTRL_POWER_ON 1

// Parameter error number
`define PARAM_ERR_NUM 8'h37

// Group index of the protection-level parameter slot
`define PROT_SLOT_GROUP 3'd0

`endif

// file: core/servo_guard_pkg.sv
// Types shared by the parameter guard
package servo_guard_pkg;
    typedef enum logic [1:0] {
        CTRL_POSITION = 2'h0,
        CTRL_SPEED = 2'h1,
        CTRL_TORQUE = 2'h2
    } ctrl_mode_t;

    typedef enum logic [2:0] {
        GRP_BASIC = 3'h0,
        GRP_GAIN = 3'h1,
        GRP_EXTSET = 3'h2,
        GRP_IO = 3'h3,
        GRP_EXTCTL = 3'h4
    } group_t;

    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_DECEL = 4'b0010,
        ST_STOPPED = 4'b0100,
        ST_FREE = 4'b1000
    } stop_state_t;
endpackage

// file: core/servo_param_guard.sv
// Parameter access guard, configuration check and forced-stop decoder
//
// Functional notes
// - Levels 0000h/000Bh/000Ch/000Fh open basic, +gain/extset, +io, all.
// - Levels 100Bh/100Ch read basic/all; only protection level writable.
// - Reset protection level is 000Bh: basic, gain, extset writable.
// - Controller parameter writes bypass the protection level.
// - Protection, absolute and stop selections apply at power-on or reset.
// - Regenerative selection applies only at power-on.
// - Regenerative option not permitted raises parameter error 37.
// - Absolute selection applies only in position control mode.
// - Absolute plus incremental linear encoder raises error 37.
// - Absolute plus loop switching raises error 37.
// - Selection 00: decelerating stop, brake released after deceleration.
// - Selection 10: decelerating stop, brake released at decel start.
// - Selection 30: immediate stop, brake released with no deceleration.
// - Selections 01/11/31 ignore stop input; alarm follows same timing.
// - In torque mode a decelerating stop from the stop input acts as immediate stop; alarm still decelerates.
// - Stop selection can disable the stop input entirely.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "servo_guard_cfg.svh"

module servo_param_guard (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stop_pin,
    input wire logic alarm,
    input wire logic decel_done,
    output logic decel_cmd,
    output logic base_off,
    output logic brake_interlock_output,
    output logic param_error,
    output logic irq
);
    // ************************************************************
    // Declarations
    // ************************************************************
    logic [15:0] regen_r, abs_r, stop_r, prot_r;
    logic [15:0] regen_act_r, abs_act_r, stop_act_r, prot_act_r;
    logic [3:0] mode_r;
    logic [4:0] status_r, mask_r;
    logic [2:0] group_r;
    logic ctrl_src_r;
    logic aw_hold_r, w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write, ctrl_reset, power_on;
    logic [4:0] rd_mask, wr_mask;
    logic wr_prot_only, wr_ok, rd_ok, wr_blocked, is_param;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_nxt;
    logic param_err_nxt, stop_act, stop_immediate, stop_used;
    logic [4:0] evt;
    servo_guard_pkg::stop_state_t state_r;
    servo_guard_pkg::ctrl_mode_t mode_act;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
            input logic [31:0] d, input logic [3:0] s);
        merge16 = old;
        if (s[0]) begin
            merge16[7:0] = d[7:0];
        end
        if (s[1]) begin
            merge16[15:8] = d[15:8];
        end
    endfunction

    // Group masks for a protection level
    function automatic logic [4:0] level_mask(input logic [15:0] lvl,
            input logic wr);
        unique case (lvl)
            `PROT_BASIC: level_mask = 5'h01;
            `PROT_B: level_mask = 5'h07;
            `PROT_C: level_mask = 5'h0F;
            `PROT_F: level_mask = 5'h1F;
            `PROT_RO_B: level_mask = wr ? 5'h00 : 5'h01;
            `PROT_RO_C: level_mask = wr ? 5'h00 : 5'h1F;
            default: level_mask = 5'h01;
        endcase
    endfunction

    function automatic logic is_param_ofs(input logic [7:0] a);
        is_param_ofs = (a == `OFS_REGEN) || (a == `OFS_ABS) ||
            (a == `OFS_STOP) || (a == `OFS_PROT);
    endfunction

    // ************************************************************
    // Access decoding
    // ************************************************************
    // Written value becomes active only on these controls, never directly
    assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign ctrl_reset = do_write && (awaddr_r == `OFS_CTRL) &&
        wstrb_r[0] && wdata_r[`CTRL_CTRL_RESET];
    assign power_on = do_write && (awaddr_r == `OFS_CTRL) &&
        wstrb_r[0] && wdata_r[`CTRL_POWER_ON];
    assign rd_mask = level_mask(prot_act_r, 1'b0);
    assign wr_mask = level_mask(prot_act_r, 1'b1);
    assign wr_prot_only = (prot_act_r == `PROT_RO_B) ||
        (prot_act_r == `PROT_RO_C);
    assign is_param = is_param_ofs(awaddr_r);
    // All parameter slots share one group; group_r picks the group
    assign wr_ok = ctrl_src_r || wr_mask[group_r] ||
        (wr_prot_only && awaddr_r == `OFS_PROT);
    assign rd_ok = rd_mask[group_r];
    assign wr_blocked = do_write && is_param && !wr_ok;
    assign mode_act = servo_guard_pkg::ctrl_mode_t'(mode_r[1:0]);

    // ************************************************************
    // Write channel
    // ************************************************************
    // Address and data taken in either order, held until response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_hold_r && !(s_axi_wvalid && s_axi_wready);
            if (do_write) begin
                s_axi_bresp <= (wr_blocked || awaddr_r > `OFS_CTRL ||
                    awaddr_r[1:0] != 2'h0) ? 2'h2 : 2'h0;
            end
        end
    end

    // ************************************************************
    // Stored parameter values
    // ************************************************************
    // Blocked writes keep the stored value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            regen_r <= `RST_REGEN;
            abs_r <= `RST_ABS;
            stop_r <= `RST_STOP;
            prot_r <= `RST_PROT;
        end else if (do_write && wr_ok) begin
            unique case (awaddr_r)
                `OFS_REGEN: regen_r <= merge16(regen_r, wdata_r, wstrb_r);
                `OFS_ABS: abs_r <= merge16(abs_r, wdata_r, wstrb_r);
                `OFS_STOP: stop_r <= merge16(stop_r, wdata_r, wstrb_r);
                `OFS_PROT: prot_r <= merge16(prot_r, wdata_r, wstrb_r);
                default: ;
            endcase
        end
    end

    // Block-side control: mode, mask, group, source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= 4'h0;
            mask_r <= 5'h00;
            group_r <= 3'h0;
            ctrl_src_r <= 1'b0;
        end else if (do_write) begin
            unique case (awaddr_r)
                `OFS_MODE: mode_r <= wstrb_r[0] ? wdata_r[3:0] : mode_r;
                `OFS_MASK: mask_r <= wstrb_r[0] ? wdata_r[4:0] : mask_r;
                `OFS_GROUP: begin
                    group_r <= wstrb_r[0] && wdata_r[2:0] < 3'h5 ?
                        wdata_r[2:0] : group_r;
                    ctrl_src_r <= wstrb_r[0] ? wdata_r[8] : ctrl_src_r;
                end
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Activation at power-on and controller reset
    // ************************************************************
    // Hardware reset counts as power-on for all active copies
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            regen_act_r <= `RST_REGEN;
            abs_act_r <= `RST_ABS;
            stop_act_r <= `RST_STOP;
            prot_act_r <= `RST_PROT;
        end else begin
            if (power_on || ctrl_reset) begin
                abs_act_r <= abs_r;
                stop_act_r <= stop_r;
                prot_act_r <= prot_r;
            end
            if (power_on) begin
                regen_act_r <= regen_r;
            end
        end
    end

    // ************************************************************
    // Configuration check
    // ************************************************************
    // Allowed regen codes are a constant table; large drives use 00 only
    localparam logic [255:0] REGEN_ALLOWED = `REGEN_ALLOWED_DEFAULT;
    always_comb begin
        param_err_nxt = !REGEN_ALLOWED[regen_act_r[7:0]];
        if (abs_act_r[`ABS_EN_BIT] &&
            mode_act == servo_guard_pkg::CTRL_POSITION) begin
            if (mode_r[`MODE_LIN_INC_BIT]) begin
                param_err_nxt = 1'b1;
            end
            if (mode_r[`MODE_LOOP_SW_BIT]) begin
                param_err_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            param_error <= 1'b0;
        end else begin
            param_error <= param_err_nxt;
        end
    end

    // ************************************************************
    // Forced-stop decode and brake sequence
    // ************************************************************
    // x1 selections drop the stop input; x0 keep it
    assign stop_used = (stop_act_r[7:0] == `STOP_SEL_00) ||
        (stop_act_r[7:0] == `STOP_SEL_10) ||
        (stop_act_r[7:0] == `STOP_SEL_30);
    assign stop_act = (stop_used && stop_pin) || alarm;
    assign stop_immediate = stop_act_r[5] ||
        (stop_used && stop_pin && mode_act == servo_guard_pkg::CTRL_TORQUE);

    // Brake released after, at start of, or without deceleration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= servo_guard_pkg::ST_RUN;
            decel_cmd <= 1'b0;
            base_off <= 1'b0;
            brake_interlock_output <= 1'b1;
        end else begin
            unique case (state_r)
                servo_guard_pkg::ST_RUN: if (stop_act) begin
                    if (stop_immediate) begin
                        state_r <= servo_guard_pkg::ST_STOPPED;
                        base_off <= 1'b1;
                        brake_interlock_output <= 1'b0;
                    end else begin
                        state_r <= servo_guard_pkg::ST_DECEL;
                        decel_cmd <= 1'b1;
                        brake_interlock_output <= !stop_act_r[4];
                    end
                end
                servo_guard_pkg::ST_DECEL: if (decel_done) begin
                    state_r <= servo_guard_pkg::ST_STOPPED;
                    decel_cmd <= 1'b0;
                    base_off <= 1'b1;
                    brake_interlock_output <= 1'b0;
                end
                servo_guard_pkg::ST_STOPPED: if (!stop_act) begin
                    state_r <= servo_guard_pkg::ST_FREE;
                end
                servo_guard_pkg::ST_FREE: begin
                    state_r <= servo_guard_pkg::ST_RUN;
                    base_off <= 1'b0;
                    brake_interlock_output <= 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // Status and interrupt
    // ************************************************************
    // Sticky bits; a set in the same cycle wins over a write-one clear
    assign evt = {state_r == servo_guard_pkg::ST_DECEL &&
        brake_interlock_output, state_r == servo_guard_pkg::ST_RUN &&
        stop_act, s_axi_arvalid && s_axi_arready &&
        is_param_ofs(s_axi_araddr) && !rd_ok, wr_blocked,
        param_err_nxt && !param_error};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= 5'h00;
            irq <= 1'b0;
        end else begin
            if (do_write && awaddr_r == `OFS_STATUS && wstrb_r[0]) begin
                status_r <= (status_r & ~wdata_r[4:0]) | evt;
            end else begin
                status_r <= status_r | evt;
            end
            irq <= |(status_r & mask_r);
        end
    end

    // ************************************************************
    // Read channel
    // ************************************************************
    // Blocked parameter reads return zero with a slave error
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = 2'h0;
        unique case (s_axi_araddr)
            `OFS_REGEN: rdata_nxt = {16'h0000, regen_r};
            `OFS_ABS: rdata_nxt = {16'h0000, abs_r};
            `OFS_STOP: rdata_nxt = {16'h0000, stop_r};
            `OFS_PROT: rdata_nxt = {16'h0000, prot_r};
            `OFS_ACTIVE: rdata_nxt = {stop_act_r, prot_act_r};
            `OFS_ACCESS: rdata_nxt = {7'h00, param_error, `PARAM_ERR_NUM,
                3'h0, wr_mask, 3'h0, rd_mask};
            `OFS_MODE: rdata_nxt = {28'h0000000, mode_r};
            `OFS_STATUS: rdata_nxt = {27'h0000000, status_r};
            `OFS_MASK: rdata_nxt = {27'h0000000, mask_r};
            `OFS_GROUP: rdata_nxt = {23'h000000, ctrl_src_r, 5'h00, group_r};
            `OFS_CTRL: rdata_nxt = 32'h0000_0000;
            default: rresp_nxt = 2'h2;
        endcase
        if (is_param_ofs(s_axi_araddr) && !rd_ok) begin
            rdata_nxt = 32'h0000_0000;
            rresp_nxt = 2'h2;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdata_nxt;
                s_axi_rresp <= rresp_nxt;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/decel_model.sv
// Load model that reports the end of a forced-stop deceleration
`timescale 1ns/10ps
`default_nettype none
module decel_model (
    input wire logic aclk,
    input wire logic decel_cmd,
    input wire logic slow,
    output logic decel_done
);
    logic [4:0] cnt_r;
    // Zero speed comes a few cycles into the ramp, later when slow
    always_ff @(posedge aclk) begin
        cnt_r <= decel_cmd ? cnt_r + 5'h01 : 5'h00;
        decel_done <= decel_cmd && cnt_r == (slow ? 5'h0C : 5'h03);
    end
endmodule
`default_nettype wire

// file: bench/servo_guard_sva.sv
// Port-level assertions for the parameter guard
`timescale 1ns/10ps
`default_nettype none
module servo_guard_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stop_pin,
    input wire logic alarm,
    input wire logic decel_done,
    input wire logic decel_cmd,
    input wire logic base_off,
    input wire logic brake_interlock_output
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************
    // Bus and stop checks
    // ****************
    // Both write halves taken on one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Four calm edges cover the free cycle on the way back to run
    sequence calm;
        (!stop_pin && !alarm) [*4];
    endsequence
    a_write_answer: assert property (wr_taken |-> ##[2:3] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |->
        ##[1:2] s_axi_rvalid) else $error("read data late");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("bvalid dropped");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid) else $error("rvalid dropped");
    a_decel_finish: assert property (
        decel_cmd && decel_done |=>
        !decel_cmd && base_off && !brake_interlock_output)
        else $error("decel end not applied");
    a_base_brake: assert property (
        $rose(base_off) |-> !brake_interlock_output)
        else $error("brake held at base off");
    a_brake_cause: assert property (
        $fell(brake_interlock_output) |-> decel_cmd || base_off)
        else $error("brake released idle");
    a_calm_run: assert property (
        calm |-> !decel_cmd && !base_off && brake_interlock_output)
        else $error("stop without cause");
    a_alarm_stop: assert property (
        $rose(alarm) && !decel_cmd && !base_off
        |-> ##[1:3] (decel_cmd || base_off)) else $error("alarm ignored");
endmodule

bind servo_param_guard servo_guard_sva servo_guard_sva_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .stop_pin(stop_pin), .alarm(alarm),
    .decel_done(decel_done), .decel_cmd(decel_cmd), .base_off(base_off),
    .brake_interlock_output(brake_interlock_output)
);
`default_nettype wire

// file: bench/test_servo_param_guard.sv
// Self-checking bench for the parameter guard
`timescale 1ns/10ps
`default_nettype none
`include "servo_guard_cfg.svh"
module test_servo_param_guard;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
    logic awready, wready, bvalid, arready, rvalid, stop_pin, alarm;
    logic decel_done, decel_cmd, base_off, brake, param_error, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rnd;
    logic [1:0] bresp, rresp;
    logic [7:0] sel_tab [6] = '{8'h00, 8'h10, 8'h30, 8'h01, 8'h11, 8'h31};
    logic [3:0] mode_tab [3] = '{4'h4, 4'h8, 4'h5};
    logic [1:0] exp_b [$];
    logic [33:0] exp_r [$];
    int num_errors = 0;
    int checked = 0;

    servo_param_guard servo_param_guard_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .stop_pin(stop_pin), .alarm(alarm),
        .decel_done(decel_done), .decel_cmd(decel_cmd), .base_off(base_off),
        .brake_interlock_output(brake), .param_error(param_error), .irq(irq)
    );
    decel_model decel_model_inst (
        .aclk(aclk), .decel_cmd(decel_cmd), .slow(slow),
        .decel_done(decel_done)
    );

    // ****************
    // Bus tasks and compares
    // ****************
    task automatic miss(input logic [33:0] g, input logic [33:0] e);
        num_errors++;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
    endtask
    task automatic cmp_bus(input logic [33:0] g, input logic [33:0] e);
        checked++;
        if (g !== e)
            miss(g, e);
    endtask
    // Pins are read at an edge, so they show the previous edge's update
    task automatic cmp_pin(input int n, input logic [4:0] e);
        logic [4:0] g;
        repeat (n) @(posedge aclk);
        g = {decel_cmd, base_off, brake, param_error, irq};
        checked++;
        if (g !== e)
            miss({29'h0, g}, {29'h0, e});
    endtask
    // Each channel is released only on the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            aw = aw && !awready;
            w = w && !wready;
            awvalid <= aw;
            wvalid <= w;
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        exp_r.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Stop input or alarm against one applied stop selection
    task automatic stop_case(input logic [7:0] sel, input logic pin,
                             input logic trq);
        logic imm, ign, hold;
        imm = sel[5] || (trq && pin);
        ign = pin && sel[0];
        hold = !sel[4];
        wr(`OFS_STOP, {24'h0, sel}, 2'h0);
        wr(`OFS_CTRL, 32'h1, 2'h0);
        stop_pin <= pin;
        alarm <= !pin;
        cmp_pin(2, ign ? 5'h04 : imm ? 5'h08 : {2'b10, hold, 2'b00});
        cmp_pin(20, ign ? 5'h04 : 5'h08);
        stop_pin <= 1'b0;
        alarm <= 1'b0;
        cmp_pin(4, 5'h04);
    endtask
    task automatic final_report;
        $display("mismatches %0d, compares %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Responses are matched against the oldest note
    always @(posedge aclk) begin
        if (bvalid && bready)
            cmp_bus({bresp, 32'h0}, {exp_b.pop_front(), 32'h0});
        if (rvalid && rready)
            cmp_bus({rresp, rdata}, exp_r.pop_front());
    end
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        $display("unexpected at %0t: run hung", $time);
        final_report;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {stop_pin, alarm, slow, awaddr, araddr, wdata} = 51'h0;
        rnd = $urandom(32'h5F225F76);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`OFS_PROT, 32'h0000000B, 2'h0);
        rd(8'h30, 32'h0, 2'h2);
        for (int i = 0; i < 12; i++) begin
            slow <= 1'($urandom);
            stop_case(sel_tab[i / 2], 1'(i), 1'b0);
        end
        wr(`OFS_MODE, 32'h2, 2'h0);
        stop_case(8'h00, 1'b1, 1'b1);
        wr(`OFS_MODE, 32'h0, 2'h0);
        wr(`OFS_STOP, 32'h31, 2'h0);
        wr(`OFS_PROT, 32'h0, 2'h0);
        rd(`OFS_ACTIVE, 32'h0000000B, 2'h0);
        wr(`OFS_CTRL, 32'h1, 2'h0);
        rd(`OFS_ACTIVE, 32'h00310000, 2'h0);
        wr(`OFS_GROUP, 32'h1, 2'h0);
        wr(`OFS_REGEN, 32'h1234, 2'h2);
        rd(`OFS_REGEN, 32'h0, 2'h2);
        wr(`OFS_GROUP, 32'h101, 2'h0);
        wr(`OFS_REGEN, 32'h1, 2'h0);
        wr(`OFS_PROT, 32'h1234, 2'h0);
        wr(`OFS_CTRL, 32'h1, 2'h0);
        rd(`OFS_REGEN, 32'h0, 2'h2);
        wr(`OFS_GROUP, 32'h0, 2'h0);
        rd(`OFS_REGEN, 32'h1, 2'h0);
        wr(`OFS_PROT, 32'h100B, 2'h0);
        wr(`OFS_CTRL, 32'h1, 2'h0);
        wr(`OFS_REGEN, 32'h0, 2'h2);
        wr(`OFS_PROT, 32'h000F, 2'h0);
        wr(`OFS_GROUP, 32'h4, 2'h0);
        rd(`OFS_REGEN, 32'h0, 2'h2);
        wr(`OFS_CTRL, 32'h1, 2'h0);
        rd(`OFS_REGEN, 32'h1, 2'h0);
        wr(`OFS_GROUP, 32'h0, 2'h0);
        // Option code 01 is not permitted; only power-on applies it
        wr(`OFS_MASK, 32'h1, 2'h0);
        wr(`OFS_CTRL, 32'h1, 2'h0);
        cmp_pin(4, 5'h04);
        wr(`OFS_CTRL, 32'h2, 2'h0);
        cmp_pin(4, 5'h07);
        wr(`OFS_STATUS, 32'h1, 2'h0);
        cmp_pin(4, 5'h06);
        wr(`OFS_REGEN, 32'h0, 2'h0);
        wr(`OFS_CTRL, 32'h2, 2'h0);
        cmp_pin(4, 5'h04);
        wr(`OFS_MASK, 32'h0, 2'h0);
        foreach (mode_tab[i]) begin
            wr(`OFS_MODE, {28'h0, mode_tab[i]}, 2'h0);
            wr(`OFS_ABS, 32'h1, 2'h0);
            wr(`OFS_CTRL, 32'h1, 2'h0);
            cmp_pin(4, {3'b001, mode_tab[i][1:0] == 2'h0, 1'b0});
            wr(`OFS_ABS, 32'h0, 2'h0);
            wr(`OFS_CTRL, 32'h1, 2'h0);
        end
        wr(`OFS_MODE, 32'h0, 2'h0);
        rnd = {16'h0, rnd[15:1], 1'b0};
        wr(`OFS_ABS, rnd, 2'h0);
        rd(`OFS_ABS, rnd, 2'h0);
        final_report;
    end
endmodule
`default_nettype wire
